// >>> loopback_pkg.sv
// Constants for framer loopback selection and per-channel controllers
package loopback_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int NUM_FRAMERS  = 8;
   localparam int CHAN_LOCS    = 72;
   localparam int FRAMER_SEL_W = 3;
   localparam int OFS_W        = 7;

   // ----------------------------------------------------------------
   // Offsets inside one framer's 80H window
   // ----------------------------------------------------------------
   localparam logic [6:0] DIAG_OFS   = 7'h0A;
   localparam logic [6:0] TX_CFG_OFS = 7'h30;
   localparam logic [6:0] RX_CFG_OFS = 7'h50;

   // Register index inside a controller's four-register group
   localparam logic [1:0] REG_CFG    = 2'h0;
   localparam logic [1:0] REG_STATUS = 2'h1;
   localparam logic [1:0] REG_ACTRL  = 2'h2;
   localparam logic [1:0] REG_DATA   = 2'h3;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int DIAG_LINE_BIT   = 4;
   localparam int DIAG_SYS_BIT    = 2;
   localparam int DIAG_BYPASS_BIT = 0;
   localparam int CFG_ENABLE_BIT  = 0;
   localparam int CFG_INDIRECT_BIT = 1;
   localparam int ACTRL_RNW_BIT   = 7;
   localparam int LOOP_BIT        = 7;
   localparam int SIGINS_BIT      = 6;
   localparam int RBS_BIT_POS     = 0;
   localparam logic [7:0] DIAG_RESET = 8'h00;
   localparam logic [7:0] CFG_RESET  = 8'h00;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam logic [1:0] ACCESS_CYCLES = 2'h2;

endpackage

// >>> chan_store.sv
// Per-channel controller: config, indirect access engine and 72-entry store
`timescale 1ns/10ps
`default_nettype none

module chan_store
   import loopback_pkg::*;
#(
   parameter int LOCS = CHAN_LOCS
)
(
   input  wire logic       ref_clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic       sel_in,
   input  wire logic       wr_in,
   input  wire logic [1:0] reg_idx_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic [6:0] chan_in,
   output logic      [7:0] rdata_out,
   output logic      [7:0] ctrl_out,
   output logic            busy_out
);

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_BUSY = 1'b1
   } acc_state_t;

   acc_state_t state_r, state_nxt;
   logic [7:0] cfg_r, cfg_nxt;
   logic [7:0] buf_r, buf_nxt;
   logic [6:0] addr_r, addr_nxt;
   logic       rnw_r, rnw_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic [7:0] store_r [LOCS];
   logic [7:0] store_nxt [LOCS];
   logic       take_req;

   assign busy_out = (state_r == ST_BUSY);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      cfg_nxt   = cfg_r;
      buf_nxt   = buf_r;
      addr_nxt  = addr_r;
      rnw_nxt   = rnw_r;
      cnt_nxt   = cnt_r;
      state_nxt = state_r;
      store_nxt = store_r;
      // Requests while busy are dropped so the access in flight is intact
      take_req  = sel_in && wr_in && reg_idx_in == REG_ACTRL && state_r == ST_IDLE
                  && cfg_r[CFG_INDIRECT_BIT];
      if (sel_in && wr_in && reg_idx_in == REG_CFG)
      begin
         cfg_nxt = wdata_in;
      end
      if (sel_in && wr_in && reg_idx_in == REG_DATA && state_r == ST_IDLE)
      begin
         buf_nxt = wdata_in;
      end
      if (take_req)
      begin
         addr_nxt  = wdata_in[6:0];
         rnw_nxt   = wdata_in[ACTRL_RNW_BIT];
         cnt_nxt   = ACCESS_CYCLES - 2'h1;
         state_nxt = ST_BUSY;
      end
      if (state_r == ST_BUSY)
      begin
         if (cnt_r == 2'h0)
         begin
            state_nxt = ST_IDLE;
            // Out-of-range addresses complete without touching the store
            if (int'(addr_r) < LOCS)
            begin
               if (rnw_r)
               begin
                  buf_nxt = store_r[addr_r];
               end
               else
               begin
                  store_nxt[addr_r] = buf_r;
               end
            end
         end
         else
         begin
            cnt_nxt = cnt_r - 2'h1;
         end
      end
   end

   // Disabled controller drives no control onto the streams
   always_comb
   begin
      ctrl_out = 8'h00;
      if (cfg_r[CFG_ENABLE_BIT] && int'(chan_in) < LOCS)
      begin
         ctrl_out = store_r[chan_in];
      end
   end

   always_comb
   begin
      unique case (reg_idx_in)
         REG_CFG:    rdata_out = cfg_r;
         REG_STATUS: rdata_out = {7'h00, busy_out};
         REG_ACTRL:  rdata_out = {rnw_r, addr_r};
         REG_DATA:   rdata_out = buf_r;
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         cfg_r   <= CFG_RESET;
         buf_r   <= 8'h00;
         addr_r  <= 7'h00;
         rnw_r   <= 1'b0;
         cnt_r   <= 2'h0;
         state_r <= ST_IDLE;
         for (int i = 0; i < LOCS; i++)
         begin
            store_r[i] <= 8'h00;
         end
      end
      else
      begin
         cfg_r   <= cfg_nxt;
         buf_r   <= buf_nxt;
         addr_r  <= addr_nxt;
         rnw_r   <= rnw_nxt;
         cnt_r   <= cnt_nxt;
         state_r <= state_nxt;
         store_r <= store_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_busy_window;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      take_req |=> busy_out [*2] ##1 !busy_out;
   endproperty
   a_busy_window: assert property (p_busy_window) else $error("busy window wrong");

   property p_read_result;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      ($fell(busy_out) && rnw_r && int'(addr_r) < LOCS) |-> buf_r == store_r[addr_r];
   endproperty
   a_read_result: assert property (p_read_result) else $error("read data not in buffer");

   property p_busy_ignore;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      (busy_out && sel_in && wr_in && reg_idx_in == REG_ACTRL) |=> $stable(addr_r);
   endproperty
   a_busy_ignore: assert property (p_busy_ignore) else $error("request taken while busy");

   property p_disabled_quiet;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
      !cfg_r[CFG_ENABLE_BIT] |-> ctrl_out == 8'h00;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("control while disabled");

   property p_reset_direct;
      @(posedge ref_clk_in)
      sys_rst_in |=> !cfg_r[CFG_INDIRECT_BIT] && !busy_out;
   endproperty
   a_reset_direct: assert property (p_reset_direct) else $error("indirect after reset");

endmodule

`default_nettype wire

// >>> per_channel_control_loopback.sv
// Framer loopback selection and transmit/receive per-channel controllers
`timescale 1ns/10ps
`default_nettype none

module per_channel_control_loopback
   import loopback_pkg::*;
#(
   parameter int NF = NUM_FRAMERS
)
(
   input  wire logic          ref_clk_in,
   input  wire logic          sys_rst_in,
   input  wire logic [9:0]    mp_addr_in,
   input  wire logic          mp_wr_in,
   input  wire logic          mp_rd_in,
   input  wire logic [7:0]    mp_wdata_in,
   output logic      [7:0]    mp_rdata_out,
   input  wire logic [6:0]    chan_idx_in,
   input  wire logic [NF*8-1:0] egress_byte_in,
   input  wire logic [NF*8-1:0] ingress_byte_in,
   input  wire logic [NF-1:0] rbs_valid_in,
   input  wire logic [NF-1:0] rbs_bit_in,
   output logic      [NF*8-1:0] egress_byte_out,
   output logic      [NF*8-1:0] tx_ctrl_out,
   output logic      [NF*8-1:0] rx_ctrl_out,
   input  wire logic [NF-1:0] tx_framer_data_in,
   input  wire logic [NF-1:0] tx_framer_clock_in,
   input  wire logic [NF-1:0] rx_line_data_in,
   input  wire logic [NF-1:0] rx_line_clock_in,
   input  wire logic [NF-1:0] rx_smooth_data_in,
   input  wire logic [NF-1:0] rx_smooth_clock_in,
   output logic      [NF-1:0] tx_line_data_out,
   output logic      [NF-1:0] tx_line_clock_out,
   output logic      [NF-1:0] rx_framer_data_out,
   output logic      [NF-1:0] rx_framer_clock_out
);

   // ----------------------------------------------------------------
   // Address split
   // ----------------------------------------------------------------
   logic [FRAMER_SEL_W-1:0] frm;
   logic [OFS_W-1:0]        ofs;
   logic                    frm_ok;
   logic                    in_tx_grp;
   logic                    in_rx_grp;

   assign frm       = mp_addr_in[9:7];
   assign ofs       = mp_addr_in[6:0];
   assign frm_ok    = int'(frm) < NF;
   assign in_tx_grp = ofs[6:2] == TX_CFG_OFS[6:2];
   assign in_rx_grp = ofs[6:2] == RX_CFG_OFS[6:2];

   // ----------------------------------------------------------------
   // Channel controllers, one transmit and one receive per framer
   // ----------------------------------------------------------------
   logic [7:0]    tx_rdata_w [NF];
   logic [7:0]    rx_rdata_w [NF];
   logic [7:0]    tx_ctrl_w  [NF];
   logic [7:0]    rx_ctrl_w  [NF];
   logic [NF-1:0] tx_busy_w;
   logic [NF-1:0] rx_busy_w;

   for (genvar f = 0; f < NF; f++)
   begin : g_ctl
      chan_store #(
         .LOCS (CHAN_LOCS)
      ) u_tx (
         .ref_clk_in (ref_clk_in),
         .sys_rst_in (sys_rst_in),
         .sel_in     (frm_ok && int'(frm) == f && in_tx_grp),
         .wr_in      (mp_wr_in),
         .reg_idx_in (ofs[1:0]),
         .wdata_in   (mp_wdata_in),
         .chan_in    (chan_idx_in),
         .rdata_out  (tx_rdata_w[f]),
         .ctrl_out   (tx_ctrl_w[f]),
         .busy_out   (tx_busy_w[f])
      );
      chan_store #(
         .LOCS (CHAN_LOCS)
      ) u_rx (
         .ref_clk_in (ref_clk_in),
         .sys_rst_in (sys_rst_in),
         .sel_in     (frm_ok && int'(frm) == f && in_rx_grp),
         .wr_in      (mp_wr_in),
         .reg_idx_in (ofs[1:0]),
         .wdata_in   (mp_wdata_in),
         .chan_in    (chan_idx_in),
         .rdata_out  (rx_rdata_w[f]),
         .ctrl_out   (rx_ctrl_w[f]),
         .busy_out   (rx_busy_w[f])
      );
   end

   // ----------------------------------------------------------------
   // Diagnostic loop selection and read-back
   // ----------------------------------------------------------------
   logic [7:0] diag_r [NF];
   logic [7:0] diag_nxt [NF];
   logic [7:0] rdata_r, rdata_nxt;

   always_comb
   begin
      diag_nxt = diag_r;
      if (mp_wr_in && frm_ok && ofs == DIAG_OFS)
      begin
         diag_nxt[frm] = mp_wdata_in;
      end
   end

   // Read data is captured on the strobe and held until the next read
   always_comb
   begin
      rdata_nxt = rdata_r;
      if (mp_rd_in)
      begin
         rdata_nxt = 8'h00;
         if (frm_ok)
         begin
            if (ofs == DIAG_OFS)
            begin
               rdata_nxt = diag_r[frm];
            end
            else if (in_tx_grp)
            begin
               rdata_nxt = tx_rdata_w[frm];
            end
            else if (in_rx_grp)
            begin
               rdata_nxt = rx_rdata_w[frm];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Data paths
   // ----------------------------------------------------------------
   logic [NF*8-1:0] egress_nxt;
   logic [NF*8-1:0] tx_ctrl_nxt;
   logic [NF*8-1:0] rx_ctrl_nxt;
   logic [NF-1:0]   txd_nxt;
   logic [NF-1:0]   txc_nxt;
   logic [NF-1:0]   rfd_nxt;
   logic [NF-1:0]   rfc_nxt;
   logic [7:0]      eg;

   always_comb
   begin
      eg = 8'h00;
      for (int i = 0; i < NF; i++)
      begin
         eg = egress_byte_in[i*8 +: 8];
         // Loop bit is already masked off while the controller is disabled
         if (tx_ctrl_w[i][LOOP_BIT])
         begin
            eg = ingress_byte_in[i*8 +: 8];
         end
         // Streams are not superframe aligned, so signaling still wins
         if (tx_ctrl_w[i][SIGINS_BIT] && rbs_valid_in[i])
         begin
            eg[RBS_BIT_POS] = rbs_bit_in[i];
         end
         egress_nxt[i*8 +: 8]  = eg;
         tx_ctrl_nxt[i*8 +: 8] = tx_ctrl_w[i];
         rx_ctrl_nxt[i*8 +: 8] = rx_ctrl_w[i];
         if (diag_r[i][DIAG_LINE_BIT])
         begin
            if (diag_r[i][DIAG_BYPASS_BIT])
            begin
               txd_nxt[i] = rx_line_data_in[i];
               txc_nxt[i] = rx_line_clock_in[i];
            end
            else
            begin
               txd_nxt[i] = rx_smooth_data_in[i];
               txc_nxt[i] = rx_smooth_clock_in[i];
            end
         end
         else
         begin
            txd_nxt[i] = tx_framer_data_in[i];
            txc_nxt[i] = tx_framer_clock_in[i];
         end
         if (diag_r[i][DIAG_SYS_BIT])
         begin
            rfd_nxt[i] = tx_framer_data_in[i];
            rfc_nxt[i] = tx_framer_clock_in[i];
         end
         else
         begin
            rfd_nxt[i] = rx_line_data_in[i];
            rfc_nxt[i] = rx_line_clock_in[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         for (int i = 0; i < NF; i++)
         begin
            diag_r[i] <= DIAG_RESET;
         end
         rdata_r             <= 8'h00;
         egress_byte_out     <= '0;
         tx_ctrl_out         <= '0;
         rx_ctrl_out         <= '0;
         tx_line_data_out    <= '0;
         tx_line_clock_out   <= '0;
         rx_framer_data_out  <= '0;
         rx_framer_clock_out <= '0;
      end
      else
      begin
         diag_r              <= diag_nxt;
         rdata_r             <= rdata_nxt;
         egress_byte_out     <= egress_nxt;
         tx_ctrl_out         <= tx_ctrl_nxt;
         rx_ctrl_out         <= rx_ctrl_nxt;
         tx_line_data_out    <= txd_nxt;
         tx_line_clock_out   <= txc_nxt;
         rx_framer_data_out  <= rfd_nxt;
         rx_framer_clock_out <= rfc_nxt;
      end
   end

   assign mp_rdata_out = rdata_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   for (genvar f = 0; f < NF; f++)
   begin : g_chk
      property p_loop_sel;
         @(posedge ref_clk_in) disable iff (sys_rst_in)
         (tx_ctrl_w[f][LOOP_BIT] && !tx_ctrl_w[f][SIGINS_BIT])
            |=> egress_byte_out[f*8 +: 8] == $past(ingress_byte_in[f*8 +: 8]);
      endproperty
      a_loop_sel: assert property (p_loop_sel) else $error("looped channel wrong");

      property p_loop_pass;
         @(posedge ref_clk_in) disable iff (sys_rst_in)
         (!tx_ctrl_w[f][LOOP_BIT] && !tx_ctrl_w[f][SIGINS_BIT])
            |=> egress_byte_out[f*8 +: 8] == $past(egress_byte_in[f*8 +: 8]);
      endproperty
      a_loop_pass: assert property (p_loop_pass) else $error("unlooped channel altered");

      property p_sig_over;
         @(posedge ref_clk_in) disable iff (sys_rst_in)
         (tx_ctrl_w[f][SIGINS_BIT] && rbs_valid_in[f])
            |=> egress_byte_out[f*8 + RBS_BIT_POS] == $past(rbs_bit_in[f]);
      endproperty
      a_sig_over: assert property (p_sig_over) else $error("signaling not inserted");

      property p_line_loop;
         @(posedge ref_clk_in) disable iff (sys_rst_in)
         (mp_wr_in && mp_addr_in == {FRAMER_SEL_W'(f), DIAG_OFS} && mp_wdata_in == 8'h10)
            ##1 !mp_wr_in
            |=> tx_line_data_out[f] == $past(rx_smooth_data_in[f])
                && tx_line_clock_out[f] == $past(rx_smooth_clock_in[f]);
      endproperty
      a_line_loop: assert property (p_line_loop) else $error("line loop not routed");

      property p_bypass;
         @(posedge ref_clk_in) disable iff (sys_rst_in)
         (diag_r[f][DIAG_LINE_BIT] && diag_r[f][DIAG_BYPASS_BIT])
            |=> tx_line_data_out[f] == $past(rx_line_data_in[f]);
      endproperty
      a_bypass: assert property (p_bypass) else $error("smoother not bypassed");

      property p_sys_loop;
         @(posedge ref_clk_in) disable iff (sys_rst_in)
         (mp_wr_in && mp_addr_in == {FRAMER_SEL_W'(f), DIAG_OFS} && mp_wdata_in == 8'h04)
            ##1 !mp_wr_in
            |=> rx_framer_data_out[f] == $past(tx_framer_data_in[f])
                && rx_framer_clock_out[f] == $past(tx_framer_clock_in[f]);
      endproperty
      a_sys_loop: assert property (p_sys_loop) else $error("system loop not routed");

      property p_diag_map;
         @(posedge ref_clk_in) disable iff (sys_rst_in)
         (mp_wr_in && mp_addr_in == {FRAMER_SEL_W'(f), DIAG_OFS})
            |=> diag_r[f] == $past(mp_wdata_in);
      endproperty
      a_diag_map: assert property (p_diag_map) else $error("diagnostic register misplaced");
   end

endmodule

`default_nettype wire

// >>> host_model.sv
// Host processor model that drives the per-framer register bus
`timescale 1ns/10ps
`default_nettype none

module host_model
(
   input  wire logic       ref_clk_in,
   input  wire logic [7:0] mp_rdata_in,
   output logic      [9:0] mp_addr_out,
   output logic            mp_wr_out,
   output logic            mp_rd_out,
   output logic      [7:0] mp_wdata_out
);
   // Idle cycles before each access, raised by the bench to act slowly
   int gap;
   // Polls that ran out while busy stayed high
   int stuck;

   initial
   begin
      mp_addr_out = 10'h000;
      mp_wr_out = 1'b0;
      mp_rd_out = 1'b0;
      mp_wdata_out = 8'h00;
   end

   // ----------------------------------------------------------------
   // Bus cycles: called at a falling edge, held through the taking edge
   // ----------------------------------------------------------------
   task automatic cyc(input logic [9:0] a, input logic w, input logic [7:0] d);
      repeat (gap) @(negedge ref_clk_in);
      mp_addr_out = a;
      mp_wr_out = w;
      mp_rd_out = !w;
      mp_wdata_out = d;
      @(negedge ref_clk_in);
      mp_wr_out = 1'b0;
      mp_rd_out = 1'b0;
      // Released lines must not keep showing the last value
      mp_addr_out = ~a;
      mp_wdata_out = ~d;
      // One idle edge so a strobe is never dropped and raised in one step
      @(negedge ref_clk_in);
   endtask

   task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
      cyc(a, 1'b1, d);
   endtask

   task automatic reg_rd(input logic [9:0] a, output logic [7:0] d);
      cyc(a, 1'b0, 8'h00);
      d = mp_rdata_in;
   endtask

   // ----------------------------------------------------------------
   // Indirect channel store access
   // ----------------------------------------------------------------
   task automatic wait_idle(input logic [9:0] b);
      logic [7:0] s;
      s = 8'hFF;
      for (int n = 0; n < 50 && s[0] !== 1'b0; n++)
      begin
         reg_rd(b + 10'h001, s);
      end
      if (s[0] !== 1'b0)
         stuck++;
   endtask

   task automatic ind_wr(input logic [9:0] b, input logic [6:0] loc, input logic [7:0] d);
      wait_idle(b);
      reg_wr(b + 10'h003, d);
      reg_wr(b + 10'h002, {1'b0, loc});
      wait_idle(b);
   endtask

   task automatic ind_rd(input logic [9:0] b, input logic [6:0] loc, output logic [7:0] d);
      wait_idle(b);
      reg_wr(b + 10'h002, {1'b1, loc});
      wait_idle(b);
      reg_rd(b + 10'h003, d);
   endtask

   // Disable streams, set indirect mode, then load all 72 locations
   task automatic fill(input logic [9:0] b, input logic [6:0] loc, input logic [7:0] v);
      reg_wr(b, 8'h02);
      for (int i = 0; i < 72; i++)
         ind_wr(b, 7'(i), (i == int'(loc)) ? v : 8'h00);
   endtask
endmodule
`default_nettype wire

// >>> per_channel_control_loopback_tb_top.sv
// Self-checking testbench for loopback selection and channel controllers
`timescale 1ns/10ps
`default_nettype none

module per_channel_control_loopback_tb_top;
   import loopback_pkg::*;

   localparam logic [9:0] TX = 10'h030;
   localparam logic [9:0] RX = 10'h050;

   logic       ref_clk_in = 1'b0;
   logic       sys_rst_in = 1'b1;
   logic [9:0] mp_addr;
   logic       mp_wr;
   logic       mp_rd;
   logic [7:0] mp_wdata;
   logic [7:0] mp_rdata;
   logic [6:0] chan_idx = 7'h00;
   logic [63:0] egr_in = {8{8'h11}};
   // Ingress bytes share the egress clock and slot index
   logic [63:0] ing_in = {8{8'h5A}};
   logic [7:0] rbs_valid = 8'h00;
   logic [7:0] rbs_bit = 8'h00;
   logic [63:0] egr_out;
   logic [63:0] tx_ctrl;
   logic [63:0] rx_ctrl;
   logic [7:0] tf = 8'h00;
   logic [7:0] rl = 8'h00;
   logic [7:0] rs = 8'h00;
   logic [7:0] txd;
   logic [7:0] txc;
   logic [7:0] rfd;
   logic [7:0] rfc;
   logic [7:0] v;
   int         errors = 0;
   int         cmp_count = 0;

   always #2.5 ref_clk_in = ~ref_clk_in;

   per_channel_control_loopback i_per_channel_control_loopback (
      .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .mp_addr_in(mp_addr),
      .mp_wr_in(mp_wr), .mp_rd_in(mp_rd), .mp_wdata_in(mp_wdata), .mp_rdata_out(mp_rdata),
      .chan_idx_in(chan_idx), .egress_byte_in(egr_in), .ingress_byte_in(ing_in),
      .rbs_valid_in(rbs_valid), .rbs_bit_in(rbs_bit), .egress_byte_out(egr_out),
      .tx_ctrl_out(tx_ctrl), .rx_ctrl_out(rx_ctrl), .tx_framer_data_in(tf),
      .tx_framer_clock_in(tf), .rx_line_data_in(rl), .rx_line_clock_in(rl),
      .rx_smooth_data_in(rs), .rx_smooth_clock_in(rs), .tx_line_data_out(txd),
      .tx_line_clock_out(txc), .rx_framer_data_out(rfd), .rx_framer_clock_out(rfc));

   host_model i_host_model (
      .ref_clk_in(ref_clk_in), .mp_rdata_in(mp_rdata), .mp_addr_out(mp_addr),
      .mp_wr_out(mp_wr), .mp_rd_out(mp_rd), .mp_wdata_out(mp_wdata));

   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_of_test;
      if (errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Registered outputs need one edge after their inputs settle
   task automatic settle;
      repeat (2) @(negedge ref_clk_in);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      i_host_model.reg_rd(TX, v);
      chk("tx_cfg", v, 8'h00);
      chk("tx_ctrl_rst", tx_ctrl[7:0], 8'h00);
      i_host_model.reg_rd(RX, v);
      chk("rx_cfg", v, 8'h00);
      i_host_model.reg_rd(10'h00A, v);
      chk("diag", v, 8'h00);
      i_host_model.reg_rd(10'h00B, v);
      chk("unmapped", v, 8'h00);
      // Direct mode selected: an indirect request must not start
      i_host_model.reg_wr(TX + 10'h002, 8'h05);
      i_host_model.reg_rd(TX + 10'h001, v);
      chk("busy_direct", v, 8'h00);
   endtask

   task automatic t_indirect;
      i_host_model.reg_wr(TX, 8'h02);
      i_host_model.reg_wr(TX + 10'h003, 8'hA5);
      i_host_model.reg_wr(TX + 10'h002, 8'h05);
      i_host_model.reg_wr(TX + 10'h002, 8'h06);
      i_host_model.wait_idle(TX);
      i_host_model.gap = 2;
      i_host_model.ind_rd(TX, 7'h06, v);
      chk("ignored_loc", v, 8'h00);
      i_host_model.ind_rd(TX, 7'h05, v);
      chk("read_back", v, 8'hA5);
      i_host_model.gap = 0;
      i_host_model.reg_wr(TX + 10'h002, 8'h85);
      i_host_model.reg_rd(TX + 10'h001, v);
      chk("busy_rise", {7'h00, v[0]}, 8'h01);
      i_host_model.wait_idle(TX);
      i_host_model.reg_rd(TX + 10'h001, v);
      chk("busy_done", {7'h00, v[0]}, 8'h00);
   endtask

   task automatic t_loop;
      i_host_model.fill(TX, 7'h03, 8'hC0);
      chan_idx = 7'h03;
      settle();
      chk("egr_off", egr_out[7:0], 8'h11);
      chk("tx_ctrl_off", tx_ctrl[7:0], 8'h00);
      i_host_model.reg_wr(TX, 8'h03);
      settle();
      chk("tx_ctrl_on", tx_ctrl[7:0], 8'hC0);
      chk("egr_loop", egr_out[7:0], 8'h5A);
      chk("egr_other", egr_out[15:8], 8'h11);
      rbs_valid = 8'h01;
      rbs_bit = 8'h01;
      settle();
      chk("egr_sig", egr_out[7:0], 8'h5B);
      rbs_valid = 8'h00;
      chan_idx = 7'h04;
      settle();
      chk("egr_pass", egr_out[7:0], 8'h11);
   endtask

   task automatic t_rx;
      i_host_model.fill(RX, 7'h07, 8'h3C);
      i_host_model.reg_wr(RX, 8'h03);
      chan_idx = 7'h07;
      settle();
      chk("rx_ctrl", rx_ctrl[7:0], 8'h3C);
      chk("rx_ctrl_f1", rx_ctrl[15:8], 8'h00);
   endtask

   task automatic t_diag;
      logic [9:0] a;
      for (int f = 0; f < 8; f++)
      begin
         a = {3'(f), 7'h0A};
         i_host_model.reg_wr(a, 8'h10);
         i_host_model.reg_rd(a, v);
         chk("diag_rw", v, 8'h10);
         {tf, rl, rs} = {8'h00, 8'h00, 8'hFF};
         settle();
         chk("line_d", {7'h00, txd[f]}, 8'h01);
         chk("line_c", {7'h00, txc[f]}, 8'h01);
         i_host_model.reg_wr(a, 8'h11);
         {tf, rl, rs} = {8'h00, 8'hFF, 8'h00};
         settle();
         chk("bypass_d", {7'h00, txd[f]}, 8'h01);
         i_host_model.reg_wr(a, 8'h04);
         {tf, rl, rs} = {8'hFF, 8'h00, 8'h00};
         settle();
         chk("tx_normal", {7'h00, txd[f]}, 8'h01);
         chk("sys_d", {7'h00, rfd[f]}, 8'h01);
         chk("sys_c", {7'h00, rfc[f]}, 8'h01);
         i_host_model.reg_wr(a, 8'h00);
      end
   endtask

   initial
   begin
      repeat (3) @(negedge ref_clk_in);
      sys_rst_in = 1'b0;
      t_reset();
      t_indirect();
      t_loop();
      t_rx();
      // Second reset with indirect mode on must fall back to direct mode
      sys_rst_in = 1'b1;
      repeat (3) @(negedge ref_clk_in);
      sys_rst_in = 1'b0;
      t_reset();
      t_diag();
      chk("busy_poll_limit", 8'(i_host_model.stuck), 8'h00);
      end_of_test();
   end

   // Two full fills take about fifteen hundred cycles; this is a generous ceiling
   initial
   begin
      repeat (20000) @(posedge ref_clk_in);
      errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
